/* File: core/io_processor_compute_datapath.sv */
// Computation datapath: operand registers, accumulator, adder, shifter, branch arithmetic
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1 - Bank of 512 sixteen-bit operand registers
// RL2 - Operand register read completes in one period
// RL3 - Bank written from accumulator; reads feed three
// RL4 - Bank indexed by the operand index pointer
// RL5 - Address register holds operand address for reference
// RL6 - Twos complement adder, second operand via addend
// RL7 - Seventeen-bit carry-accumulator plus sixteen-bit addend
// RL8 - Subtract inverts addend and adds one
// RL9 - Add one period, write-back one more
// RL10 - Unsigned x minus y toggles carry when x>=y
// RL11 - Left shifts 0-31, circular or end-off
// RL12 - Count from addend low bits; right inverts
// RL13 - Shift one period, instruction two periods
// RL14 - Zero count unchanged; end-off past 16 clears
// RL15 - Carry is bit 16 of shift operand/result
// RL16 - Accumulator loads from many sources, drives outputs
// RL17 - Logical product formed at accumulator input, no delay
// RL18 - Branch codes use hidden background accumulator
// RL19 - Adder forms branch program addresses
// RL20 - Carry loaded by adder, shifter, channel tests
// RL21 - Addend loads from B, stack, operands, memory
// RL22 - Program address advances by one, loads branches
module io_processor_compute_datapath #(
   parameter int OPREG_DEPTH = iop_compute_pkg::OPREG_NUM
) (
   input  wire logic                                clk_sys,        // System clock, 125 MHz
   input  wire logic                                sys_rst,        // Synchronous reset, active high
   input  wire logic [iop_compute_pkg::INDEX_W-1:0] operandIndexPointer, // Operand register index
   input  wire logic                                opRegRead,      // Read operand register
   input  wire iop_compute_pkg::rd_dest_t           opRegDest,      // Where the read word goes
   input  wire logic                                opRegWrite,     // Write accumulator to operand register
   input  wire logic                                accLoad,        // Load accumulator from accSrc
   input  wire iop_compute_pkg::acc_src_t           accSrc,         // Accumulator source select
   input  wire logic                                logicalProduct, // AND incoming word into accumulator
   input  wire logic                                addendLoad,     // Load addend from addendSrc
   input  wire iop_compute_pkg::addend_src_t        addendSrc,      // Addend source select
   input  wire logic                                aluStart,       // Start add, subtract or shift
   input  wire iop_compute_pkg::alu_op_t            aluOp,          // Functional unit operation
   input  wire logic                                branchStart,    // Start branch address arithmetic
   input  wire logic                                branchRelative, // Add displacement, else enter value
   input  wire logic [iop_compute_pkg::CODE_W-1:0]  issuingInstruction, // Issuing instruction code
   input  wire logic                                pAdvance,       // Sequential instruction executed
   input  wire logic                                carryLoad,      // Load carry from channel flag
   input  wire logic                                carryFlag,      // Channel flag value
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  bData,          // B register contents
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  memData,        // Local memory read data
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  ioData,         // I/O channel input data
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  stackData,      // Instruction stack parcel
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  dField,         // Instruction d field, extended
   input  wire logic [iop_compute_pkg::WORD_W-1:0]  kField,         // Instruction k field, extended
   output logic      [iop_compute_pkg::WORD_W-1:0]  accOut,         // Accumulator contents
   output logic                                     carryOut,       // Carry bit
   output logic      [iop_compute_pkg::WORD_W-1:0]  addendOut,      // Addend register contents
   output logic      [iop_compute_pkg::WORD_W-1:0]  memAddrOut,     // Memory reference address
   output logic      [iop_compute_pkg::WORD_W-1:0]  progAddrOut,    // Program address
   output logic                                     unitBusy        // Write-back cycle pending
);
   localparam int W  = iop_compute_pkg::WORD_W;
   localparam int WW = iop_compute_pkg::WIDE_W;
   localparam int CW = iop_compute_pkg::COUNT_W;

   logic [W-1:0]  acc_reg;
   logic          carry_reg;
   logic [W-1:0]  addend_reg;
   logic [W-1:0]  memory_reference_address_reg;
   logic [W-1:0]  pAddr_reg;
   logic [WW-1:0] result_reg;
   logic          resultPending_reg;
   logic [W-1:0]  bgAcc_reg;
   logic          branchPending_reg;
   logic          rdValid_reg;
   iop_compute_pkg::rd_dest_t rdDest_reg;
   logic [W-1:0]  rdData;
   logic          isBranchCode;
   logic [WW-1:0] aluResult;
   logic [W-1:0]  accIncoming;

   // ********
   // Operand register bank
   // ********
   operand_reg_bank #(
      .DEPTH (OPREG_DEPTH),
      .WIDTH (W),
      .AW    (iop_compute_pkg::INDEX_W)
   ) u_bank (
      .clk_sys (clk_sys),
      .addr    (operandIndexPointer), // RL4
      .wrEn    (opRegWrite),          // RL1
      .wrData  (acc_reg),             // RL3
      .rdData  (rdData)               // RL2
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdValid_reg <= 1'b0;
         rdDest_reg  <= iop_compute_pkg::RD_TO_ACC;
      end else begin
         rdValid_reg <= opRegRead; // RL2
         rdDest_reg  <= opRegDest;
      end
   end

   // ********
   // Functional units
   // ********
   // Top 17 bits after a left shift by k
   function automatic logic [WW-1:0] shiftWin(input logic [iop_compute_pkg::WIN_W-1:0] w,
                                              input logic [CW-1:0] k);
      logic [iop_compute_pkg::WIN_W-1:0] s;
      s = w << k;
      return s[iop_compute_pkg::WIN_TOP:iop_compute_pkg::WIN_LOW];
   endfunction

   always_comb begin
      logic [WW-1:0] x;
      logic [WW-1:0] zw;
      x  = {carry_reg, acc_reg}; // RL15
      zw = '0;
      unique case (aluOp)
         iop_compute_pkg::OP_ADD:
            aluResult = x + {1'b0, addend_reg}; // RL6 RL7
         iop_compute_pkg::OP_SUB:
            aluResult = x + {1'b0, ~addend_reg} + {zw[WW-1:1], 1'b1}; // RL8 RL10
         iop_compute_pkg::OP_SHL_CIRC:
            aluResult = shiftWin({x, x, x}, addend_reg[CW-1:0]); // RL11 RL12
         iop_compute_pkg::OP_SHL_ENDOFF:
            aluResult = shiftWin({x, zw, zw}, addend_reg[CW-1:0]); // RL11 RL14
         // Right shifts: left shifter, inverted count
         iop_compute_pkg::OP_SHR_CIRC:
            aluResult = shiftWin({x[iop_compute_pkg::RWRAP_W-1:0], x, x, 3'h0},
                                 ~addend_reg[CW-1:0]); // RL12
         iop_compute_pkg::OP_SHR_ENDOFF:
            aluResult = shiftWin({zw, zw[iop_compute_pkg::RWRAP_W-1:0], x, 3'h0},
                                 ~addend_reg[CW-1:0]); // RL12 RL14
         default:
            aluResult = x;
      endcase
   end

   // Compute in the start cycle, write back in the next
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         result_reg        <= '0;
         resultPending_reg <= 1'b0;
      end else begin
         resultPending_reg <= aluStart; // RL9 RL13
         if (aluStart) begin
            result_reg <= aluResult;
         end
      end
   end

   // ********
   // Branch arithmetic on the background accumulator
   // ********
   assign isBranchCode = (issuingInstruction >= iop_compute_pkg::BRANCH_CODE_LO) &&
                         (issuingInstruction <= iop_compute_pkg::BRANCH_CODE_HI); // RL18

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bgAcc_reg         <= iop_compute_pkg::WORD_ZERO;
         branchPending_reg <= 1'b0;
      end else begin
         branchPending_reg <= branchStart && isBranchCode;
         if (branchStart && isBranchCode) begin
            // Visible accumulator untouched; sum or entered value lands in the hidden one
            bgAcc_reg <= branchRelative ? pAddr_reg + addend_reg : addend_reg; // RL18 RL19
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pAddr_reg <= iop_compute_pkg::WORD_ZERO;
      end else if (branchPending_reg) begin
         pAddr_reg <= bgAcc_reg; // RL22
      end else if (pAdvance) begin
         pAddr_reg <= pAddr_reg + iop_compute_pkg::WORD_ONE; // RL22
      end
   end

   // ********
   // Accumulator and carry
   // ********
   always_comb begin
      unique case (accSrc)
         iop_compute_pkg::ACC_FROM_B:      accIncoming = bData;
         iop_compute_pkg::ACC_FROM_MEM:    accIncoming = memData;
         iop_compute_pkg::ACC_FROM_IO:     accIncoming = ioData;
         iop_compute_pkg::ACC_FROM_DFIELD: accIncoming = dField;
         iop_compute_pkg::ACC_FROM_KFIELD: accIncoming = kField;
         default:                          accIncoming = bData;
      endcase
   end

   // Write-back beats an operand read, which beats a plain load
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         acc_reg <= iop_compute_pkg::WORD_ZERO;
      end else if (resultPending_reg) begin
         acc_reg <= result_reg[W-1:0]; // RL9 RL15
      end else if (rdValid_reg && rdDest_reg == iop_compute_pkg::RD_TO_ACC) begin
         acc_reg <= logicalProduct ? acc_reg & rdData : rdData; // RL3 RL17
      end else if (accLoad) begin
         acc_reg <= logicalProduct ? acc_reg & accIncoming : accIncoming; // RL16 RL17
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         carry_reg <= 1'b0;
      end else if (resultPending_reg) begin
         carry_reg <= result_reg[WW-1]; // RL20
      end else if (carryLoad) begin
         carry_reg <= carryFlag; // RL20
      end
   end

   // ********
   // Addend and memory address registers
   // ********
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         addend_reg <= iop_compute_pkg::WORD_ZERO;
      end else if (rdValid_reg && rdDest_reg == iop_compute_pkg::RD_TO_ADDEND) begin
         addend_reg <= rdData; // RL3 RL21
      end else if (addendLoad) begin
         unique case (addendSrc)
            iop_compute_pkg::ADD_FROM_B:      addend_reg <= bData;     // RL21
            iop_compute_pkg::ADD_FROM_ISTACK: addend_reg <= stackData; // RL21
            iop_compute_pkg::ADD_FROM_MEM:    addend_reg <= memData;   // RL21
            default:                          addend_reg <= addend_reg;
         endcase
      end
   end

   // Held untouched until the next operand read aimed at it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         memory_reference_address_reg <= iop_compute_pkg::WORD_ZERO;
      end else if (rdValid_reg && rdDest_reg == iop_compute_pkg::RD_TO_MAR) begin
         memory_reference_address_reg <= rdData; // RL5
      end
   end

   assign accOut      = acc_reg;
   assign carryOut    = carry_reg;
   assign addendOut   = addend_reg;
   assign memAddrOut  = memory_reference_address_reg;
   assign progAddrOut = pAddr_reg;
   assign unitBusy    = resultPending_reg || branchPending_reg;

   // ********
   // Assertions
   // ********
   sequence s_addIssued;
      aluStart && aluOp == iop_compute_pkg::OP_ADD;
   endsequence

   property p_addTwoCycles;
      @(posedge clk_sys) disable iff (sys_rst)
      s_addIssued |-> ##2 ({carry_reg, acc_reg} == $past({carry_reg, acc_reg}, 2) + {1'b0, $past(addend_reg, 2)});
   endproperty
   a_addTwoCycles: assert property (p_addTwoCycles) else $error("Add result wrong or late"); // RL9

   property p_subCarry;
      @(posedge clk_sys) disable iff (sys_rst)
      aluStart && aluOp == iop_compute_pkg::OP_SUB && acc_reg >= addend_reg
         |-> ##2 carry_reg != $past(carry_reg, 2);
   endproperty
   a_subCarry: assert property (p_subCarry) else $error("Carry not toggled on subtract"); // RL10

   property p_zeroShift;
      @(posedge clk_sys) disable iff (sys_rst)
      aluStart && addend_reg[CW-1:0] == '0 &&
         (aluOp == iop_compute_pkg::OP_SHL_CIRC || aluOp == iop_compute_pkg::OP_SHL_ENDOFF)
         |-> ##2 {carry_reg, acc_reg} == $past({carry_reg, acc_reg}, 2);
   endproperty
   a_zeroShift: assert property (p_zeroShift) else $error("Zero count shift changed operand"); // RL14

   property p_endOffClears;
      @(posedge clk_sys) disable iff (sys_rst)
      aluStart && addend_reg[CW-1:0] > 5'h10 &&
         (aluOp == iop_compute_pkg::OP_SHL_ENDOFF || aluOp == iop_compute_pkg::OP_SHR_ENDOFF)
         |-> ##2 (acc_reg == '0 && !carry_reg);
   endproperty
   a_endOffClears: assert property (p_endOffClears) else $error("Long end-off shift not cleared"); // RL14

   property p_circRotate;
      @(posedge clk_sys) disable iff (sys_rst)
      aluStart && aluOp == iop_compute_pkg::OP_SHL_CIRC && addend_reg[CW-1:0] == 5'h01
         |-> ##2 {carry_reg, acc_reg} == {$past(acc_reg, 2), $past(carry_reg, 2)};
   endproperty
   a_circRotate: assert property (p_circRotate) else $error("Circular shift by one wrong"); // RL15

   property p_branchKeepsAcc;
      @(posedge clk_sys) disable iff (sys_rst)
      branchStart && isBranchCode && !aluStart && !accLoad && !opRegRead && !resultPending_reg && !rdValid_reg
         |=> $stable(acc_reg) ##1 progAddrOut == $past(bgAcc_reg);
   endproperty
   a_branchKeepsAcc: assert property (p_branchKeepsAcc) else $error("Branch disturbed accumulator"); // RL18

   property p_pAdvance;
      @(posedge clk_sys) disable iff (sys_rst)
      pAdvance && !branchPending_reg |=> pAddr_reg == $past(pAddr_reg) + iop_compute_pkg::WORD_ONE;
   endproperty
   a_pAdvance: assert property (p_pAdvance) else $error("Program address did not advance"); // RL22

   property p_marFromRead;
      @(posedge clk_sys) disable iff (sys_rst)
      opRegRead && opRegDest == iop_compute_pkg::RD_TO_MAR |-> ##2 memAddrOut == $past(rdData);
   endproperty
   a_marFromRead: assert property (p_marFromRead) else $error("Address register not loaded"); // RL5

   property p_marHolds;
      @(posedge clk_sys) disable iff (sys_rst)
      !(rdValid_reg && rdDest_reg == iop_compute_pkg::RD_TO_MAR) |=> $stable(memAddrOut);
   endproperty
   a_marHolds: assert property (p_marHolds) else $error("Address register changed unasked"); // RL5

   property p_andNoDelay;
      @(posedge clk_sys) disable iff (sys_rst)
      accLoad && logicalProduct && !resultPending_reg && !rdValid_reg
         |=> acc_reg == ($past(acc_reg) & $past(accIncoming));
   endproperty
   a_andNoDelay: assert property (p_andNoDelay) else $error("Logical product wrong or late"); // RL17

   property p_carryFlag;
      @(posedge clk_sys) disable iff (sys_rst)
      carryLoad && !resultPending_reg |=> carry_reg == $past(carryFlag);
   endproperty
   a_carryFlag: assert property (p_carryFlag) else $error("Carry not loaded from flag"); // RL20
endmodule // io_processor_compute_datapath
`default_nettype wire

/* File: core/iop_compute_pkg.sv */
// Shared constants and types for the I/O processor computation datapath
package iop_compute_pkg;
   localparam int WORD_W    = 16;
   localparam int WIDE_W    = 17;
   localparam int OPREG_NUM = 512;
   localparam int INDEX_W   = 9;
   localparam int COUNT_W   = 5;
   localparam int CODE_W    = 7;
   localparam int WIN_W     = 51;
   localparam int WIN_TOP   = 50;
   localparam int WIN_LOW   = 34;
   localparam int RWRAP_W   = 14;
   localparam int RPAD_W    = 3;

   // Branch instruction code range, octal 070 through 137
   localparam logic [CODE_W-1:0] BRANCH_CODE_LO = 7'h38;
   localparam logic [CODE_W-1:0] BRANCH_CODE_HI = 7'h5f;

   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_ONE  = 16'h0001;

   typedef enum logic [2:0] {
      OP_ADD, OP_SUB, OP_SHL_CIRC, OP_SHL_ENDOFF, OP_SHR_CIRC, OP_SHR_ENDOFF
   } alu_op_t;

   typedef enum logic [2:0] {
      ACC_FROM_B, ACC_FROM_MEM, ACC_FROM_IO, ACC_FROM_DFIELD, ACC_FROM_KFIELD
   } acc_src_t;

   typedef enum logic [1:0] {
      ADD_FROM_B, ADD_FROM_ISTACK, ADD_FROM_MEM
   } addend_src_t;

   typedef enum logic [1:0] {
      RD_TO_ACC, RD_TO_ADDEND, RD_TO_MAR
   } rd_dest_t;
endpackage : iop_compute_pkg

/* File: core/operand_reg_bank.sv */
// Operand register bank with registered read data
`timescale 1ns/1ps
`default_nettype none
module operand_reg_bank #(
   parameter int DEPTH = 512,
   parameter int WIDTH = 16,
   parameter int AW    = 9
) (
   input  wire logic             clk_sys,  // System clock
   input  wire logic [AW-1:0]    addr,     // Word index
   input  wire logic             wrEn,     // Write strobe
   input  wire logic [WIDTH-1:0] wrData,   // Write data
   output logic      [WIDTH-1:0] rdData    // Read data, one cycle after addr
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[addr] <= wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      rdData <= mem[addr];
   end
endmodule // operand_reg_bank
`default_nettype wire

/* File: tb/ctl_issue_model.sv */
// Instruction issue stand-in that drives the datapath control inputs
`timescale 1ns/1ps
`default_nettype none
module ctl_issue_model (
   input  wire logic                         clk_sys,             // System clock
   output var  logic [8:0]                   operandIndexPointer, // Register index
   output var  logic                         opRegRead,           // Read pulse
   output var  iop_compute_pkg::rd_dest_t    opRegDest,           // Read destination
   output var  logic                         opRegWrite,          // Write pulse
   output var  logic                         accLoad,             // Acc load pulse
   output var  iop_compute_pkg::acc_src_t    accSrc,              // Acc source
   output var  logic                         logicalProduct,      // AND mode
   output var  logic                         addendLoad,          // Addend load pulse
   output var  iop_compute_pkg::addend_src_t addendSrc,           // Addend source
   output var  logic                         aluStart,            // Unit start pulse
   output var  iop_compute_pkg::alu_op_t     aluOp,               // Unit operation
   output var  logic                         branchStart,         // Branch pulse
   output var  logic                         branchRelative,      // Relative branch
   output var  logic [6:0]                   issuingInstruction,  // Instruction code
   output var  logic                         pAdvance,            // Sequential step
   output var  logic                         carryLoad            // Flag test pulse
);
   logic [8:0] pend = 9'h000;
   logic [8:0] now  = 9'h000;

   assign {opRegRead, opRegWrite, accLoad, addendLoad, aluStart, branchStart, pAdvance, carryLoad, logicalProduct} = now;

   initial begin
      {operandIndexPointer, branchRelative, issuingInstruction} = 17'h00000;
      opRegDest = iop_compute_pkg::RD_TO_ACC;
      accSrc = iop_compute_pkg::ACC_FROM_B;
      addendSrc = iop_compute_pkg::ADD_FROM_B;
      aluOp = iop_compute_pkg::OP_ADD;
   end

   task automatic cycle();
      now = pend;
      pend = 9'h000;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [8:0] i, input iop_compute_pkg::rd_dest_t d);
      operandIndexPointer = i;
      opRegDest = d;
      pend[8] = 1'b1;
   endtask

   task automatic wr(input logic [8:0] i);
      operandIndexPointer = i;
      pend[7] = 1'b1;
   endtask

   task automatic acc(input iop_compute_pkg::acc_src_t s, input logic lp);
      accSrc = s;
      pend[6] = 1'b1;
      pend[0] = lp;
   endtask

   task automatic addend(input iop_compute_pkg::addend_src_t s);
      addendSrc = s;
      pend[5] = 1'b1;
   endtask

   task automatic alu(input iop_compute_pkg::alu_op_t op);
      aluOp = op;
      pend[4] = 1'b1;
   endtask

   task automatic br(input logic [6:0] code, input logic rel);
      issuingInstruction = code;
      branchRelative = rel;
      pend[3] = 1'b1;
   endtask

   task automatic step(input logic advance);
      pend[advance ? 2 : 1] = 1'b1;
   endtask
endmodule // ctl_issue_model
`default_nettype wire

/* File: tb/test_io_processor_compute_datapath.sv */
// Self-checking bench for the computation datapath
`timescale 1ns/1ps
`default_nettype none
module test_io_processor_compute_datapath;
   typedef struct { int due; int sel; logic [16:0] val; } note_t;
   typedef enum int {S_ACC, S_ADD, S_MAR, S_P, S_BSY} sel_t;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [8:0]  operandIndexPointer;
   logic        opRegRead, opRegWrite, accLoad, logicalProduct, addendLoad, aluStart;
   logic        branchStart, branchRelative, pAdvance, carryLoad, carryFlag, carryOut, unitBusy;
   logic [6:0]  issuingInstruction;
   logic [15:0] bData, memData, ioData, stackData, dField, kField;
   logic [15:0] accOut, addendOut, memAddrOut, progAddrOut;
   iop_compute_pkg::rd_dest_t    opRegDest;
   iop_compute_pkg::acc_src_t    accSrc;
   iop_compute_pkg::addend_src_t addendSrc;
   iop_compute_pkg::alu_op_t     aluOp;
   note_t       q[$];
   string       nm[5] = '{"acc", "addend", "memaddr", "progaddr", "busy"};
   logic [4:0]  cntTab[5] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h1f};
   logic [6:0]  brTab[4] = '{7'h37, 7'h38, 7'h5f, 7'h60};
   int          seed = 32'h5c3fe255;
   int          cyc = 0, fails = 0, checks_done = 0;
   logic        useB = 1'b0;
   logic [15:0] bVal, mAcc, mAdd, mMar, mP;
   logic        mC;
   logic [15:0] bank [int];

   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;

   ctl_issue_model i_ctl (.clk_sys, .operandIndexPointer, .opRegRead, .opRegDest, .opRegWrite, .accLoad,
      .accSrc, .logicalProduct, .addendLoad, .addendSrc, .aluStart, .aluOp, .branchStart, .branchRelative,
      .issuingInstruction, .pAdvance, .carryLoad);
   io_processor_compute_datapath i_dut (.clk_sys, .sys_rst, .operandIndexPointer, .opRegRead, .opRegDest,
      .opRegWrite, .accLoad, .accSrc, .logicalProduct, .addendLoad, .addendSrc, .aluStart, .aluOp, .branchStart,
      .branchRelative, .issuingInstruction, .pAdvance, .carryLoad, .carryFlag, .bData, .memData, .ioData,
      .stackData, .dField, .kField, .accOut, .carryOut, .addendOut, .memAddrOut, .progAddrOut, .unitBusy);

   function automatic logic [16:0] pick(input int s);
      case (s)
         S_ACC: return {carryOut, accOut};
         S_ADD: return {1'b0, addendOut};
         S_MAR: return {1'b0, memAddrOut};
         S_P: return {1'b0, progAddrOut};
         default: return {16'h0000, unitBusy};
      endcase
   endfunction

   function automatic logic [16:0] aluRes(input iop_compute_pkg::alu_op_t op, input logic [16:0] x,
                                          input logic [15:0] y);
      logic [16:0] r;
      r = x;
      if (op == iop_compute_pkg::OP_ADD) r = x + {1'b0, y};
      else if (op == iop_compute_pkg::OP_SUB) r = x + {1'b0, ~y} + 17'h00001;
      else for (int i = 0; i < int'(y[4:0]); i++) begin
         if (op == iop_compute_pkg::OP_SHL_CIRC) r = {r[15:0], r[16]};
         else if (op == iop_compute_pkg::OP_SHL_ENDOFF) r = {r[15:0], 1'b0};
         else if (op == iop_compute_pkg::OP_SHR_CIRC) r = {r[0], r[16:1]};
         else r = {1'b0, r[16:1]};
      end
      return r;
   endfunction

   always @(posedge clk_sys) begin
      #2;
      while (q.size() > 0 && q[0].due <= cyc) begin
         checks_done++;
         if (pick(q[0].sel) !== q[0].val) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm[q[0].sel], q[0].val, pick(q[0].sel));
         end
         void'(q.pop_front());
      end
   end

   task automatic note(input int sel, input logic [16:0] v, input int lag);
      q.push_back('{cyc + lag, sel, v});
   endtask

   task automatic tick();
      logic [95:0] r = {$random(seed), $random(seed), $random(seed)};
      i_ctl.cycle();
      {memData, ioData, stackData, dField, kField} = r[79:0];
      bData = useB ? bVal : r[95:80];
      carryFlag = ^r;
      useB = 1'b0;
   endtask

   task automatic doAcc(input iop_compute_pkg::acc_src_t s, input logic lp);
      logic [15:0] src[5] = '{bData, memData, ioData, dField, kField};
      mAcc = lp ? (mAcc & src[s]) : src[s];
      i_ctl.acc(s, lp);
      tick();
      note(S_ACC, {mC, mAcc}, 0);
   endtask

   task automatic doAddend(input iop_compute_pkg::addend_src_t s);
      logic [15:0] src[3] = '{bData, stackData, memData};
      mAdd = src[s];
      i_ctl.addend(s);
      tick();
      note(S_ADD, {1'b0, mAdd}, 0);
   endtask

   task automatic doWrite(input int i);
      bank[i] = mAcc;
      i_ctl.wr(9'(i));
      tick();
   endtask

   task automatic doRead(input int i, input iop_compute_pkg::rd_dest_t d);
      if (d == iop_compute_pkg::RD_TO_ACC) mAcc = bank[i];
      else if (d == iop_compute_pkg::RD_TO_ADDEND) mAdd = bank[i];
      else mMar = bank[i];
      i_ctl.rd(9'(i), d);
      tick();
      note(S_ACC, {mC, mAcc}, 1);
      note(S_ADD, {1'b0, mAdd}, 1);
      note(S_MAR, {1'b0, mMar}, 1);
      tick();
   endtask

   task automatic doAlu(input iop_compute_pkg::alu_op_t op);
      logic [16:0] r = aluRes(op, {mC, mAcc}, mAdd);
      i_ctl.alu(op);
      tick();
      note(S_BSY, 17'h00001, 0);
      note(S_ACC, {mC, mAcc}, 0);
      note(S_ACC, r, 1);
      note(S_BSY, 17'h00000, 1);
      {mC, mAcc} = r;
      tick();
   endtask

   task automatic doBranch(input logic [6:0] code, input logic rel);
      logic hit = code >= 7'h38 && code <= 7'h5f;
      if (hit) mP = rel ? mP + mAdd : mAdd;
      i_ctl.br(code, rel);
      tick();
      note(S_BSY, {16'h0000, hit}, 0);
      note(S_P, {1'b0, mP}, 1);
      note(S_ACC, {mC, mAcc}, 1);
      tick();
   endtask

   task automatic doStep(input logic advance);
      if (advance) mP = mP + 16'h0001;
      else mC = carryFlag;
      i_ctl.step(advance);
      tick();
      note(S_P, {1'b0, mP}, 0);
      note(S_ACC, {mC, mAcc}, 0);
   endtask

   task automatic test_done();
      if (q.size() != 0) fails++;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(2000 * 8);
      fails++;
      test_done();
   end

   initial begin
      int ix[3];
      {bData, memData, ioData, stackData, dField, kField, carryFlag} = 97'h0;
      {mAcc, mAdd, mMar, mP, mC} = 65'h0;
      repeat (16) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      tick();
      for (int s = 0; s < 5; s++) note(s, 17'h00000, 0);
      $display("test reset done");
      for (int s = 0; s < 5; s++) begin
         doAcc(iop_compute_pkg::acc_src_t'(s), 1'b0);
         doAcc(iop_compute_pkg::acc_src_t'(s), 1'b1);
      end
      for (int s = 0; s < 3; s++) doAddend(iop_compute_pkg::addend_src_t'(s));
      $display("test sources done");
      ix = '{0, 511, 1 + ($random(seed) & 32'h1fd)};
      for (int i = 0; i < 3; i++) begin
         doAcc(iop_compute_pkg::ACC_FROM_KFIELD, 1'b0);
         doWrite(ix[i]);
         doRead(ix[i], iop_compute_pkg::RD_TO_MAR);
      end
      for (int i = 0; i < 3; i++) begin
         doRead(ix[i], iop_compute_pkg::RD_TO_ADDEND);
         doAcc(iop_compute_pkg::ACC_FROM_B, 1'b0);
         doRead(ix[i], iop_compute_pkg::RD_TO_ACC);
      end
      $display("test registers done");
      for (int op = 0; op < 6; op++) begin
         for (int k = 0; k < 6; k++) begin
            bVal = 16'($random(seed));
            if (k < 5) bVal[4:0] = cntTab[k];
            doStep(1'b0);
            useB = 1'b1;
            doAcc(iop_compute_pkg::ACC_FROM_DFIELD, 1'b0);
            doAddend(iop_compute_pkg::ADD_FROM_B);
            doAlu(iop_compute_pkg::alu_op_t'(op));
         end
      end
      bVal = 16'($random(seed));
      useB = 1'b1;
      tick();
      useB = 1'b1;
      doAcc(iop_compute_pkg::ACC_FROM_B, 1'b0);
      doAddend(iop_compute_pkg::ADD_FROM_B);
      doAlu(iop_compute_pkg::OP_SUB);
      $display("test arithmetic done");
      for (int k = 0; k < 8; k++) begin
         doAddend(iop_compute_pkg::ADD_FROM_MEM);
         doStep(1'b1);
         doBranch(brTab[k / 2], k % 2 == 1);
      end
      $display("test branches done");
      tick();
      tick();
      test_done();
   end
endmodule // test_io_processor_compute_datapath
`default_nettype wire
